// File: src/osf_pkg.sv
// Constants and types shared by the output supervision and failsafe block.
package osf_pkg;
    localparam int NCH = 8;
    localparam int ADDR_W = 8;
    // Register byte offsets.
    localparam logic [7:0] OFF_SETTINGS = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_OUT_BYTE = 8'h08;
    localparam logic [7:0] OFF_OUT_BIT = 8'h0c;
    localparam logic [7:0] OFF_FORCE = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_DIAG = 8'h18;
    localparam logic [7:0] OFF_DELAY_BASE = 8'h20;
    localparam logic [7:0] OFF_FS_BASE = 8'h40;
    // Word index ranges of the per-channel tables.
    localparam logic [5:0] IDX_DELAY_BASE = 6'h08;
    localparam logic [5:0] IDX_FS_BASE = 6'h10;
    // General settings fields.
    localparam int SET_WEB_LOCK = 0;
    localparam int SET_FORCE_LOCK = 1;
    localparam int SET_EMCY_ALL = 2;
    localparam int SET_EMCY_SUPPLY = 3;
    localparam int SET_EMCY_ACT = 4;
    localparam int SET_LCU_LSB = 5;
    localparam int SET_EOE = 7;
    localparam logic [7:0] SETTINGS_RST = 8'h00;
    localparam logic [7:0] SETTINGS_MASK = 8'hff;
    // Local control unit startup codes.
    localparam logic [1:0] LCU_LOCKED = 2'h0;
    localparam logic [1:0] LCU_DISABLED = 2'h1;
    localparam logic [1:0] LCU_RUN = 2'h2;
    // Command fields.
    localparam int CMD_ACTIVATE = 0;
    localparam int CMD_RESTORE = 1;
    // Bit-format output entry fields: subindex 1..8 and its value.
    localparam int BIT_SUB_LSB = 0;
    localparam int BIT_VAL = 8;
    localparam logic [3:0] SUB_FIRST = 4'h1;
    localparam logic [3:0] SUB_LAST = 4'h8;
    // Force register fields.
    localparam int FORCE_EN = 0;
    localparam int FORCE_OUT_LSB = 8;
    localparam int FORCE_IN_LSB = 16;
    // Status register fields.
    localparam int ST_STATE_LSB = 0;
    localparam int ST_FAILSAFE = 2;
    localparam int ST_FORCE = 3;
    localparam int ST_OUT_LSB = 8;
    localparam int ST_MON_LSB = 16;
    // Diagnosis register fields.
    localparam int DG_ERR_LSB = 0;
    localparam int DG_ACT_LSB = 8;
    // Failsafe codes.
    localparam logic [1:0] FS_LOW = 2'h0;
    localparam logic [1:0] FS_HIGH = 2'h1;
    localparam logic [1:0] FS_HOLD = 2'h2;
    localparam logic [1:0] FS_RST = FS_LOW;
    // Timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [7:0] DELAY_DEF_MS = 8'h50;
    localparam logic [7:0] STATIC_MS = 8'h64;
    localparam logic [7:0] DELAY_MAX_MS = 8'hff;
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_PREOP = 2'b01,
        ST_OP = 2'b10
    } osf_state_type;
endpackage

// File: src/osf_surv_timer.sv
// Per-channel surveillance delay timer with one-millisecond resolution.
`timescale 1ns/1ps
module osf_surv_timer (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic edge_i,
    input wire logic [7:0] delay_i,
    output logic monitor_o
);
    import osf_pkg::*;

    logic [7:0] cnt;
    logic seen_edge;
    logic monitor;
    logic [7:0] next_cnt;
    logic next_seen_edge;
    logic next_monitor;
    logic [7:0] limit;

    assign monitor_o = monitor;

    always_comb begin
        next_cnt = cnt;
        next_seen_edge = seen_edge;
        // A channel with no edge yet is static and is filtered by the fixed delay.
        limit = seen_edge ? delay_i : STATIC_MS;
        if (edge_i) begin
            next_cnt = 8'h00;
            next_seen_edge = 1'b1;
        end else if (tick_i && cnt != DELAY_MAX_MS) begin
            next_cnt = cnt + 8'h01;
        end
        // Monitoring waits for the delay after every edge.
        next_monitor = !edge_i && (next_cnt >= limit);
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt <= 8'h00;
            seen_edge <= 1'b0;
            monitor <= 1'b0;
        end else if (ce_i) begin
            cnt <= next_cnt;
            seen_edge <= next_seen_edge;
            monitor <= next_monitor;
        end
    end
endmodule

// File: src/osf_top.sv
// Output channel control with surveillance delay, failsafe and device settings.
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module osf_top #(
    parameter int MS_CYCLES_P = osf_pkg::MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [osf_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic comm_ok_i,
    input wire logic eoe_master_i,
    input wire logic [osf_pkg::NCH-1:0] act_i,
    input wire logic [osf_pkg::NCH-1:0] in_i,
    output logic [osf_pkg::NCH-1:0] out_o,
    output logic [osf_pkg::NCH-1:0] in_data_o,
    output logic [osf_pkg::NCH-1:0] chan_err_o,
    output logic web_lock_o,
    output logic web_access_o,
    output logic force_active_o,
    output logic emcy_disable_all_o,
    output logic emcy_disable_supply_o,
    output logic emcy_disable_act_o,
    output logic [1:0] lcu_startup_o,
    output logic op_o,
    output logic failsafe_o
);
    import osf_pkg::*;

    localparam logic [16:0] TICK_LAST = 17'(MS_CYCLES_P - 1);

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    osf_state_type state, next_state;
    logic [7:0] settings, next_settings;
    logic [7:0] delay [NCH];
    logic [7:0] next_delay [NCH];
    logic [1:0] fs_code [NCH];
    logic [1:0] next_fs_code [NCH];
    logic [NCH-1:0] out_data, next_out_data;
    logic force_en, next_force_en;
    logic [NCH-1:0] force_out, next_force_out;
    logic [NCH-1:0] force_in, next_force_in;
    logic [16:0] tick_cnt, next_tick_cnt;
    logic tick, next_tick;
    logic [31:0] rdata, next_rdata;
    logic wait_q, next_wait;
    logic [NCH-1:0] out_q, next_out;
    logic [NCH-1:0] in_q, next_in;
    logic [NCH-1:0] err_q, next_err;
    logic web_access, next_web_access;
    logic force_act_q, next_force_act;
    logic failsafe_q, next_failsafe;
    logic op_q, next_op;
    logic [NCH-1:0] fs_val;
    logic [NCH-1:0] monitor;
    logic [NCH-1:0] out_edge;
    logic [31:0] cur_word;
    logic [31:0] wword;
    logic [5:0] idx;
    logic wr_go;
    logic rd_first;
    logic params_open;
    logic force_ok;
    logic comm_lost;

    assign avs_readdata_o = rdata;
    assign avs_waitrequest_o = wait_q;
    assign out_o = out_q;
    assign in_data_o = in_q;
    assign chan_err_o = err_q;
    assign web_lock_o = settings[SET_WEB_LOCK];
    assign web_access_o = web_access;
    assign force_active_o = force_act_q;
    assign emcy_disable_all_o = settings[SET_EMCY_ALL];
    assign emcy_disable_supply_o = settings[SET_EMCY_SUPPLY];
    assign emcy_disable_act_o = settings[SET_EMCY_ACT];
    assign lcu_startup_o = settings[SET_LCU_LSB +: 2];
    assign op_o = op_q;
    assign failsafe_o = failsafe_q;

    assign idx = avs_address_i[7:2];
    assign wr_go = avs_write_i && !wait_q;
    assign rd_first = avs_read_i && wait_q;
    // Parameters are only taken over while the device is not yet operational.
    assign params_open = (state != ST_OP);
    assign force_ok = force_en && !settings[SET_FORCE_LOCK];
    assign comm_lost = (state == ST_OP) && !comm_ok_i;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            always_comb begin
                case (fs_code[g])
                    FS_LOW: fs_val[g] = 1'b0;
                    FS_HIGH: fs_val[g] = 1'b1;
                    FS_HOLD: fs_val[g] = out_q[g];
                    default: fs_val[g] = 1'b0;
                endcase
            end
            assign out_edge[g] = next_out[g] ^ out_q[g];
            osf_surv_timer u_timer (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .ce_i(ce_i),
                .tick_i(tick),
                .edge_i(out_edge[g]),
                .delay_i(delay[g]),
                .monitor_o(monitor[g])
            );
        end
    endgenerate

    // Word currently addressed, used for reads and for byte-enable merging.
    always_comb begin
        cur_word = 32'h0000_0000;
        if (idx >= IDX_DELAY_BASE && idx < IDX_DELAY_BASE + 6'(NCH)) begin
            cur_word[7:0] = delay[3'(idx - IDX_DELAY_BASE)];
        end else if (idx >= IDX_FS_BASE && idx < IDX_FS_BASE + 6'(NCH)) begin
            cur_word[1:0] = fs_code[3'(idx - IDX_FS_BASE)];
        end else begin
            case (avs_address_i)
                OFF_SETTINGS: cur_word[7:0] = settings;
                OFF_OUT_BYTE: cur_word[NCH-1:0] = out_data;
                OFF_FORCE: begin
                    cur_word[FORCE_EN] = force_en;
                    cur_word[FORCE_OUT_LSB +: NCH] = force_out;
                    cur_word[FORCE_IN_LSB +: NCH] = force_in;
                end
                OFF_STATUS: begin
                    cur_word[ST_STATE_LSB +: 2] = state;
                    cur_word[ST_FAILSAFE] = failsafe_q;
                    cur_word[ST_FORCE] = force_act_q;
                    cur_word[ST_OUT_LSB +: NCH] = out_q;
                    cur_word[ST_MON_LSB +: NCH] = monitor;
                end
                OFF_DIAG: begin
                    cur_word[DG_ERR_LSB +: NCH] = err_q;
                    cur_word[DG_ACT_LSB +: NCH] = act_i;
                end
                default: cur_word = 32'h0000_0000;
            endcase
        end
        wword = be_merge(cur_word, avs_writedata_i, avs_byteenable_i);
    end

    always_comb begin
        next_state = state;
        next_settings = settings;
        next_delay = delay;
        next_fs_code = fs_code;
        next_out_data = out_data;
        next_force_en = force_en;
        next_force_out = force_out;
        next_force_in = force_in;
        next_rdata = rdata;
        // Waitrequest drops for exactly one cycle in the second cycle of a request.
        next_wait = !((avs_read_i || avs_write_i) && wait_q);
        next_tick = (tick_cnt == TICK_LAST);
        next_tick_cnt = next_tick ? 17'h00000 : tick_cnt + 17'h00001;
        if (rd_first) begin
            next_rdata = cur_word;
        end
        if (state == ST_INIT) begin
            next_state = ST_PREOP;
        end
        if (wr_go) begin
            if (params_open && idx >= IDX_DELAY_BASE && idx < IDX_DELAY_BASE + 6'(NCH)) begin
                next_delay[3'(idx - IDX_DELAY_BASE)] = wword[7:0];
            end else if (params_open && idx >= IDX_FS_BASE
                         && idx < IDX_FS_BASE + 6'(NCH)) begin
                next_fs_code[3'(idx - IDX_FS_BASE)] = wword[1:0];
            end else begin
                case (avs_address_i)
                    OFF_SETTINGS: begin
                        if (params_open) begin
                            next_settings = wword[7:0] & SETTINGS_MASK;
                        end
                    end
                    OFF_CMD: begin
                        if (wword[CMD_ACTIVATE] && state == ST_PREOP) begin
                            next_state = ST_OP;
                        end
                        if (wword[CMD_RESTORE]) begin
                            next_settings = SETTINGS_RST;
                            for (int c = 0; c < NCH; c++) begin
                                next_delay[c] = DELAY_DEF_MS;
                                next_fs_code[c] = FS_RST;
                            end
                            next_force_en = 1'b0;
                        end
                    end
                    OFF_OUT_BYTE: begin
                        if (state == ST_OP) begin
                            next_out_data = wword[NCH-1:0];
                        end
                    end
                    OFF_OUT_BIT: begin
                        if (state == ST_OP && wword[BIT_SUB_LSB +: 4] >= SUB_FIRST
                            && wword[BIT_SUB_LSB +: 4] <= SUB_LAST) begin
                            next_out_data[3'(wword[BIT_SUB_LSB +: 4] - SUB_FIRST)] =
                                wword[BIT_VAL];
                        end
                    end
                    OFF_FORCE: begin
                        next_force_en = wword[FORCE_EN];
                        next_force_out = wword[FORCE_OUT_LSB +: NCH];
                        next_force_in = wword[FORCE_IN_LSB +: NCH];
                    end
                    default: next_state = next_state;
                endcase
            end
        end
    end

    // Output path: forcing first, then failsafe, then master data.
    always_comb begin
        next_failsafe = comm_lost;
        next_force_act = force_ok;
        // Registered from the next state so the flag tracks the state without a lag.
        next_op = (next_state == ST_OP);
        if (force_ok) begin
            next_out = force_out;
            next_in = force_in;
        end else begin
            next_in = in_i;
            if (comm_lost) begin
                next_out = fs_val;
            end else if (state == ST_OP) begin
                next_out = out_data;
            end else begin
                next_out = {NCH{1'b0}};
            end
        end
        // A mismatch between target and actual only counts once monitoring runs.
        next_err = monitor & (out_q ^ act_i);
        next_web_access = settings[SET_EOE] && eoe_master_i
                          && !settings[SET_WEB_LOCK];
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state <= ST_INIT;
            settings <= SETTINGS_RST;
            for (int c = 0; c < NCH; c++) begin
                delay[c] <= DELAY_DEF_MS;
                fs_code[c] <= FS_RST;
            end
            out_data <= {NCH{1'b0}};
            force_en <= 1'b0;
            force_out <= {NCH{1'b0}};
            force_in <= {NCH{1'b0}};
            tick_cnt <= 17'h00000;
            tick <= 1'b0;
            rdata <= 32'h0000_0000;
            wait_q <= 1'b1;
        end else if (ce_i) begin
            state <= next_state;
            settings <= next_settings;
            delay <= next_delay;
            fs_code <= next_fs_code;
            out_data <= next_out_data;
            force_en <= next_force_en;
            force_out <= next_force_out;
            force_in <= next_force_in;
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
            rdata <= next_rdata;
            wait_q <= next_wait;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            out_q <= {NCH{1'b0}};
            in_q <= {NCH{1'b0}};
            err_q <= {NCH{1'b0}};
            web_access <= 1'b0;
            force_act_q <= 1'b0;
            failsafe_q <= 1'b0;
            op_q <= 1'b0;
        end else if (ce_i) begin
            out_q <= next_out;
            in_q <= next_in;
            err_q <= next_err;
            web_access <= next_web_access;
            force_act_q <= next_force_act;
            failsafe_q <= next_failsafe;
            op_q <= next_op;
        end
    end
endmodule

// File: dv/osf_top_checker.sv
// Concurrent checks on the ports of the output supervision block.
`timescale 1ns/1ps
module osf_top_checker #(
    parameter int MS_CYCLES_P = 10
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic comm_ok_i,
    input wire logic eoe_master_i,
    input wire logic [osf_pkg::NCH-1:0] act_i,
    input wire logic [osf_pkg::NCH-1:0] out_o,
    input wire logic [osf_pkg::NCH-1:0] chan_err_o,
    input wire logic web_lock_o,
    input wire logic web_access_o,
    input wire logic emcy_disable_all_o,
    input wire logic emcy_disable_supply_o,
    input wire logic emcy_disable_act_o,
    input wire logic [1:0] lcu_startup_o,
    input wire logic op_o,
    input wire logic failsafe_o
);
    import osf_pkg::*;
    logic [NCH-1:0] prev_out, next_prev_out;
    logic seen, next_seen;
    int cyc, next_cyc;
    logic [5:0] params;
    assign params = {web_lock_o, emcy_disable_all_o, emcy_disable_supply_o,
        emcy_disable_act_o, lcu_startup_o};
    // Until the last channel first switches it waits the fixed static delay.
    always_comb begin
        next_prev_out = resetn_i ? out_o : '0;
        next_seen = resetn_i && (seen || out_o[NCH-1] != prev_out[NCH-1]);
        next_cyc = resetn_i ? cyc + 32'(ce_i) : 0;
    end
    always_ff @(posedge clk_i) begin
        prev_out <= next_prev_out;
        seen <= next_seen;
        cyc <= next_cyc;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence req_start;
        (avs_read_i || avs_write_i) && avs_waitrequest_o && ce_i;
    endsequence
    sequence loss_two;
        (op_o && !comm_ok_i)[*2];
    endsequence
    one_wait_a: assert property (req_start |=> !avs_waitrequest_o) else $error("no answer");
    wait_pulse_a: assert property (!avs_waitrequest_o && ce_i |=> avs_waitrequest_o)
        else $error("wait low too long");
    lock_access_a: assert property (web_lock_o[*3] |-> !web_access_o) else $error("lock");
    access_cause_a: assert property (web_access_o |-> $past(eoe_master_i))
        else $error("access without tunnel");
    fs_loss_a: assert property (loss_two |-> failsafe_o) else $error("no failsafe");
    fs_clear_a: assert property (comm_ok_i[*2] |-> !failsafe_o) else $error("failsafe");
    op_sticky_a: assert property (op_o |=> op_o) else $error("left operation");
    param_lock_a: assert property (op_o && $past(op_o) && $changed(params) |-> params == '0)
        else $error("setting changed in operation");
    static_quiet_a: assert property (!seen && cyc < 99 * MS_CYCLES_P |-> !chan_err_o[NCH-1])
        else $error("early static error");
    err_cause_a: assert property ((chan_err_o & ~$past(out_o ^ act_i)) == '0)
        else $error("error without mismatch");
endmodule
bind osf_top osf_top_checker #(.MS_CYCLES_P(MS_CYCLES_P)) chk_u (.clk_i, .resetn_i, .ce_i,
    .avs_read_i, .avs_write_i, .avs_waitrequest_o, .comm_ok_i, .eoe_master_i, .act_i,
    .out_o, .chan_err_o, .web_lock_o, .web_access_o, .emcy_disable_all_o,
    .emcy_disable_supply_o, .emcy_disable_act_o, .lcu_startup_o, .op_o, .failsafe_o);

// File: dv/osf_master_model.sv
// Fieldbus master model driving the register bus and the link status.
`timescale 1ns/1ps
module osf_master_model (
    input wire logic clk_i,
    input wire logic [31:0] avs_readdata_i,
    input wire logic avs_waitrequest_i,
    output logic [osf_pkg::ADDR_W-1:0] avs_address_o,
    output logic avs_read_o,
    output logic avs_write_o,
    output logic [31:0] avs_writedata_o,
    output logic [3:0] avs_byteenable_o,
    output logic comm_ok_o,
    output logic eoe_master_o,
    output logic stuck_o
);
    import osf_pkg::*;
    initial begin
        {avs_address_o, avs_read_o, avs_write_o, avs_writedata_o} = '0;
        {avs_byteenable_o, eoe_master_o, stuck_o} = '0;
        comm_ok_o = 1'b1;
    end
    // Parameter blocks are sent before activation; later ones probe refusal.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {avs_address_o, avs_writedata_o, avs_byteenable_o} <= {a, d, be};
        {avs_write_o, avs_read_o} <= {w, !w};
        // The slave owes one wait cycle; a longer wait is flagged but still awaited.
        do begin
            @(posedge clk_i);
            n++;
            if (n == 3) stuck_o <= 1'b1;
        end while (avs_waitrequest_i !== 1'b0);
        q = avs_readdata_i;
        {avs_read_o, avs_write_o} <= 2'b00;
        // Released lines show the inverse so a stale value is never trusted.
        {avs_address_o, avs_writedata_o} <= {~a, ~d};
    endtask
    task automatic link(input logic c, input logic e);
        @(posedge clk_i);
        comm_ok_o <= c;
        eoe_master_o <= e;
    endtask
endmodule

// File: dv/osf_top_tb_top.sv
// Self-checking bench for the output supervision and failsafe block.
`timescale 1ns/1ps
module osf_top_tb_top;
    import osf_pkg::*;
    localparam int MSC = 10;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] in_r = 8'h00, in_prev = 8'h00, act_r = 8'h00, fault = 8'h00;
    logic [31:0] seed = 32'h00014fbe;
    logic [7:0] outd, v, exp_o;
    logic [7:0] dly [NCH];
    logic [1:0] fs [NCH];
    int cyc = 0;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [ADDR_W-1:0] adr;
    logic [31:0] wdat, rdat;
    logic [3:0] be_s;
    logic rd_s, wr_s, wait_s, comm_ok, eoe_m, stuck, web_lock, web_acc, frc;
    logic e_all, e_sup, e_act, op_s, fs_s;
    logic [1:0] lcu;
    logic [NCH-1:0] out_s, in_d, err_s;
    osf_top #(.MS_CYCLES_P(MSC)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
        .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
        .avs_byteenable_i(be_s), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_s),
        .comm_ok_i(comm_ok), .eoe_master_i(eoe_m), .act_i(act_r), .in_i(in_r),
        .out_o(out_s), .in_data_o(in_d), .chan_err_o(err_s), .web_lock_o(web_lock),
        .web_access_o(web_acc), .force_active_o(frc), .emcy_disable_all_o(e_all),
        .emcy_disable_supply_o(e_sup), .emcy_disable_act_o(e_act), .lcu_startup_o(lcu),
        .op_o(op_s), .failsafe_o(fs_s));
    osf_master_model master_u (.clk_i(clk_i), .avs_readdata_i(rdat), .avs_waitrequest_i(wait_s),
        .avs_address_o(adr), .avs_read_o(rd_s), .avs_write_o(wr_s), .avs_writedata_o(wdat),
        .avs_byteenable_o(be_s), .comm_ok_o(comm_ok), .eoe_master_o(eoe_m), .stuck_o(stuck));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        master_u.bus(1'b1, a, d, be, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        master_u.bus(1'b0, a, ~e, 4'hf, q);
        check($sformatf("reg_%h", a), q & m, e & m);
    endtask
    task automatic settle;
        repeat (3) @(negedge clk_i);
    endtask
    always #5 clk_i = ~clk_i;
    // The load echoes the driven level, inverted on channels with a fault.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        act_r <= out_s ^ fault;
        in_r <= seed[15:8] ^ 8'(cyc);
        in_prev <= in_r;
        if (cyc == 4000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        fault <= 8'h81;
        for (int i = 0; i < NCH; i++) begin
            rd(OFF_DELAY_BASE + 8'(4 * i), 32'(DELAY_DEF_MS), '1);
            rd(OFF_FS_BASE + 8'(4 * i), 32'(FS_RST), '1);
        end
        rd(OFF_STATUS, 32'(ST_PREOP), 32'h3);
        rd(8'h1c, 32'h0, '1);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            v = {1'b1, 2'(i), seed[4:1], i[0]};
            wr(OFF_SETTINGS, 32'(v), 4'hf);
            master_u.link(1'b1, i != 2);
            settle();
            check("lcu", 32'(lcu), 32'(i));
            check("web_lock", 32'(web_lock), 32'(v[SET_WEB_LOCK]));
            check("emcy", 32'({e_act, e_sup, e_all}), 32'(v[4:2]));
            check("web_access", 32'(web_acc), 32'(i == 0));
            check("in_data", 32'(in_d), 32'(in_prev));
            rd(OFF_SETTINGS, 32'(v), '1);
        end
        seed = lfsr(seed);
        wr(OFF_SETTINGS, 32'h02, 4'hf);
        wr(OFF_FORCE, {8'h0, seed[23:16], seed[15:8] & 8'h7e, 8'h01}, 4'hf);
        settle();
        check("force", 32'(frc), 32'h0);
        check("out", 32'(out_s), 32'h0);
        wr(OFF_SETTINGS, 32'h44, 4'hf);
        settle();
        check("force", 32'(frc), 32'h1);
        check("out", 32'(out_s), 32'(seed[15:8] & 8'h7e));
        check("in_data", 32'(in_d), 32'(seed[23:16]));
        wr(OFF_FORCE, 32'h0, 4'hf);
        for (int i = 0; i < NCH; i++) begin
            seed = lfsr(seed);
            dly[i] = (i == 0) ? 8'h03 : seed[7:0];
            fs[i] = 2'(i % 3);
            wr(OFF_DELAY_BASE + 8'(4 * i), 32'(dly[i]), 4'hf);
            wr(OFF_FS_BASE + 8'(4 * i), 32'(fs[i]), 4'hf);
        end
        wr(OFF_DELAY_BASE + 8'h08, 32'h0, 4'h0);
        for (int i = 0; i < NCH; i++) begin
            rd(OFF_DELAY_BASE + 8'(4 * i), 32'(dly[i]), '1);
            rd(OFF_FS_BASE + 8'(4 * i), 32'(fs[i]), '1);
        end
        wr(OFF_OUT_BYTE, 32'hff, 4'hf);
        settle();
        check("out", 32'(out_s), 32'h0);
        // Channel 7 never switched, so its fault shows only after the static delay.
        while (cyc < 16 + 985) @(negedge clk_i);
        check("err7", 32'(err_s[7]), 32'h0);
        while (cyc < 16 + 1030) @(negedge clk_i);
        check("err7", 32'(err_s[7]), 32'h1);
        wr(OFF_CMD, 32'h1, 4'hf);
        settle();
        check("op", 32'(op_s), 32'h1);
        wr(OFF_SETTINGS, 32'h01, 4'hf);
        rd(OFF_SETTINGS, 32'h44, '1);
        seed = lfsr(seed);
        outd = seed[7:0];
        wr(OFF_OUT_BYTE, 32'(outd), 4'hf);
        settle();
        check("out", 32'(out_s), 32'(outd));
        for (int s = 0; s < 10; s++) begin
            seed = lfsr(seed);
            wr(OFF_OUT_BIT, {23'h0, seed[0], 4'h0, 4'(s)}, 4'hf);
            if (s >= 1 && s <= 8) outd[s - 1] = seed[0];
            settle();
            check("out", 32'(out_s), 32'(outd));
        end
        outd[0] = ~outd[0];
        wr(OFF_OUT_BIT, {23'h0, outd[0], 8'h01}, 4'hf);
        repeat (15) @(negedge clk_i);
        check("err0", 32'(err_s[0]), 32'h0);
        repeat (30) @(negedge clk_i);
        check("err0", 32'(err_s[0]), 32'h1);
        master_u.link(1'b0, 1'b0);
        settle();
        for (int i = 0; i < NCH; i++) begin
            exp_o[i] = (fs[i] == FS_HOLD) ? outd[i] : (fs[i] == FS_HIGH);
        end
        check("out", 32'(out_s), 32'(exp_o));
        check("failsafe", 32'(fs_s), 32'h1);
        master_u.link(1'b1, 1'b0);
        settle();
        check("out", 32'(out_s), 32'(outd));
        wr(OFF_CMD, 32'h2, 4'hf);
        rd(OFF_SETTINGS, 32'h0, '1);
        rd(OFF_DELAY_BASE, 32'(DELAY_DEF_MS), '1);
        rd(OFF_FS_BASE + 8'h04, 32'(FS_RST), '1);
        check("stuck", 32'(stuck), 32'h0);
        summarize();
    end
endmodule
